// File: lcs_top.sv
// capture sequencer: sample capture, trigger match, delay count, state control
// assumes target clock, qualifiers, samples, strobes and bus are asynchronous pins
`timescale 1ns/1ps
`include "lcs_cfg.svh"
module lcs_top import lcs_pkg::*; #(
	parameter int MEM_AW = `LCS_MEM_AW,
	parameter bit FLUSH_EN = 1'b1
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic tgt_clk_i,
	input wire logic [1:0] clk_qual_i,
	input wire lcs_sample_t tgt_sample_i,
	input wire logic [7:0] control_strobe_port_i,
	input wire logic [7:0] data_bus_i,
	output lcs_sample_t rd_sample_o,
	output lcs_state_t rd_state_o,
	output logic flush_done_o,
	output logic capture_done_o,
	output logic error_o,
	output logic buf_ready_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	logic tclk_m_ff, tclk_s_ff, tclk_d_ff;
	logic [1:0] qual_m_ff, qual_s_ff;
	lcs_sample_t smp_m_ff, smp_s_ff;
	logic [7:0] stb_m_ff, stb_s_ff, stb_d_ff, bus_m_ff, bus_s_ff;
	logic [7:0] stb_evt;
	lcs_ctrl_t ctrl_ff, bus_ctrl;
	lcs_state_t state_ff;
	logic qclk, ctrl_wr, clr_cmd, rd_cmd;
	logic arm_cmd, force_a_cmd, force_b_cmd, stop_cmd;
	logic [`LCS_TRIG_AW-1:0] trig_addr_ff;
	logic [`LCS_NGRP-1:0] tmem [2**`LCS_TRIG_AW];
	logic [`LCS_NGRP-1:0] hit;
	logic [`LCS_SAMPLE_W-1:0] smp_vec;
	logic sec_b, trig_hit, trig_a_evt, trig_b_evt;
	lcs_sample_t smem [2**MEM_AW];
	logic [MEM_AW-1:0] smp_addr_ff;
	logic [`LCS_FLUSH_W-1:0] flush_cnt_ff;
	logic flush_done, capturing;
	logic fifo_valid, fifo_ready, pop, push_req;
	logic [`LCS_SAMPLE_W-1:0] fifo_dout;
	logic [`LCS_DLY_W-1:0] dly_ff;
	logic [`LCS_TAIL_W-1:0] tail_ff;
	logic dly_step, mid_evt, end_evt;
	lcs_sample_t rd_sample_ff;
	logic flush_done_ff, capture_done_ff, error_ff;

	// two-stage synchronisers for every pin
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			tclk_m_ff <= 1'b0;
			tclk_s_ff <= 1'b0;
			tclk_d_ff <= 1'b0;
			qual_m_ff <= '0;
			qual_s_ff <= '0;
			smp_m_ff <= '0;
			smp_s_ff <= '0;
			stb_m_ff <= '0;
			stb_s_ff <= '0;
			stb_d_ff <= '0;
			bus_m_ff <= '0;
			bus_s_ff <= '0;
		end else begin
			tclk_m_ff <= tgt_clk_i;
			tclk_s_ff <= tclk_m_ff;
			tclk_d_ff <= tclk_s_ff;
			qual_m_ff <= clk_qual_i;
			qual_s_ff <= qual_m_ff;
			smp_m_ff <= tgt_sample_i;
			smp_s_ff <= smp_m_ff;
			stb_m_ff <= control_strobe_port_i;
			stb_s_ff <= stb_m_ff;
			stb_d_ff <= stb_s_ff;
			bus_m_ff <= data_bus_i;
			bus_s_ff <= bus_m_ff;
		end
	end

	// strobe rising edges and decoded commands
	assign stb_evt = stb_s_ff & ~stb_d_ff;
	assign bus_ctrl = lcs_ctrl_t'(bus_s_ff);
	assign ctrl_wr = stb_evt[`LCS_STB_CTRL];
	assign clr_cmd = stb_evt[`LCS_STB_CLR];
	assign rd_cmd = stb_evt[`LCS_STB_RD];
	assign arm_cmd = ctrl_wr & ~bus_ctrl.cnt_mode;
	assign force_a_cmd = ctrl_wr & bus_ctrl.force_a;
	assign force_b_cmd = ctrl_wr & bus_ctrl.force_b;
	assign stop_cmd = ctrl_wr & bus_ctrl.stop;

	// delayed, qualified sample clock; no sampling while trigger memory is programmed
	assign qclk = (ctrl_ff.falling ? (~tclk_s_ff & tclk_d_ff) : (tclk_s_ff & ~tclk_d_ff))
		& (qual_s_ff[0] == ctrl_ff.qa_pol) & (qual_s_ff[1] == ctrl_ff.qb_pol)
		& ~ctrl_ff.cnt_mode;

	// capture control register
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			ctrl_ff <= lcs_ctrl_t'(`LCS_CTRL_RST);
		else if (clr_cmd)
			ctrl_ff <= lcs_ctrl_t'(`LCS_CTRL_RST); // see RL16
		else if (ctrl_wr)
			ctrl_ff <= bus_ctrl; // see RL18
	end
	chk_ctrl_clear: assert property (clr_cmd |=> ctrl_ff == '0 && trig_addr_ff == '0) // see RL16
		else $error("control register or trigger address not cleared");

	// trigger memory: one bit per group per location, address steps on write
	always_ff @(posedge clk_sys_i) begin
		if (stb_evt[`LCS_STB_TRIG])
			tmem[trig_addr_ff] <= bus_s_ff[`LCS_NGRP-1:0]; // see RL15
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			trig_addr_ff <= '0;
		else if (clr_cmd)
			trig_addr_ff <= '0;
		else if (stb_evt[`LCS_STB_TRIG])
			trig_addr_ff <= trig_addr_ff + 1'b1; // see RL15
	end
	chk_trig_step: assert property (stb_evt[`LCS_STB_TRIG] && !clr_cmd // see RL15
		|=> trig_addr_ff == `LCS_TRIG_AW'($past(trig_addr_ff) + 1'b1))
		else $error("trigger address did not advance");

	// match lookup: every group must hit in the active pattern section
	assign smp_vec = smp_s_ff;
	assign sec_b = (state_ff != LCS_ST_FLUSHED); // see RL19
	for (genvar g = 0; g < `LCS_NGRP; g++) begin : g_match
		assign hit[g] = tmem[{sec_b, smp_vec[g*`LCS_GRP_W +: `LCS_GRP_W]}][g];
	end
	assign trig_hit = &hit;
	// only the event for the next state is looked for
	assign trig_a_evt = qclk & trig_hit & (state_ff == LCS_ST_FLUSHED); // see RL11
	assign trig_b_evt = qclk & trig_hit & (state_ff == LCS_ST_TRIG_A); // see RL19

	// sample path through the two-entry buffer into sample memory
	assign capturing = (state_ff == LCS_ST_ARMED) || (state_ff == LCS_ST_FLUSHED)
		|| (state_ff == LCS_ST_TRIG_A) || (state_ff == LCS_ST_TRIG_B)
		|| (state_ff == LCS_ST_DLY);
	assign push_req = qclk & capturing; // see RL5
	assign fifo_ready = ~rd_cmd;
	assign pop = fifo_valid & fifo_ready;

	lcs_fifo2 #(
		.W(`LCS_SAMPLE_W),
		.DEPTH(`LCS_FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(push_req),
		.in_ready_o(buf_ready_o),
		.in_data_i(smp_vec),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_ready),
		.out_data_o(fifo_dout)
	);
	chk_no_write_end: assert property (state_ff == LCS_ST_END |-> !push_req) // see RL5
		else $error("sample pushed after end of capture");
	chk_idle_no_push: assert property (state_ff == LCS_ST_RESET |-> !push_req) // see RL5
		else $error("sample pushed while not armed");

	// sample memory keeps its contents; only buffer drains write it
	always_ff @(posedge clk_sys_i) begin
		if (pop)
			smem[smp_addr_ff] <= lcs_sample_t'(fifo_dout); // see RL2 RL17
	end

	// sample address: cleared by reset strobe, stepped by writes and reads
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			smp_addr_ff <= '0;
		else if (clr_cmd)
			smp_addr_ff <= '0; // see RL1
		else if (pop || rd_cmd)
			smp_addr_ff <= smp_addr_ff + 1'b1; // see RL2 RL6
	end
	chk_addr_clear: assert property (clr_cmd |=> smp_addr_ff == '0) // see RL1
		else $error("sample address not cleared by reset strobe");
	chk_addr_step: assert property ((pop || rd_cmd) && !clr_cmd // see RL2
		|=> smp_addr_ff == MEM_AW'($past(smp_addr_ff) + 1'b1))
		else $error("sample address did not advance");

	// readback word: read then post-increment
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			rd_sample_ff <= '0;
		else if (rd_cmd)
			rd_sample_ff <= smem[smp_addr_ff]; // see RL6 RL16
	end

	// flush counter saturates after the flush length of writes
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			flush_cnt_ff <= '0;
		else if (clr_cmd || (state_ff == LCS_ST_RESET))
			flush_cnt_ff <= '0;
		else if (pop && flush_cnt_ff != `LCS_FLUSH_W'(`LCS_FLUSH_LEN))
			flush_cnt_ff <= flush_cnt_ff + 1'b1; // see RL3
	end
	assign flush_done = FLUSH_EN ? (flush_cnt_ff == `LCS_FLUSH_W'(`LCS_FLUSH_LEN)) : 1'b1; // see RL4
	chk_flush_hold: assert property (FLUSH_EN && state_ff == LCS_ST_ARMED // see RL3
		&& !flush_done && !clr_cmd |=> state_ff != LCS_ST_FLUSHED)
		else $error("flush ended before enough writes");

	// delay counter: byte preload, then counts toward its terminal value
	assign dly_step = qclk & (state_ff == LCS_ST_TRIG_B)
		& (~ctrl_ff.by_events | trig_hit); // see RL8 RL9
	assign mid_evt = dly_step & (dly_ff == '1); // see RL10
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			dly_ff <= '0;
		else if (stb_evt[`LCS_STB_DLY_LO])
			dly_ff[7:0] <= bus_s_ff; // see RL7 RL15
		else if (stb_evt[`LCS_STB_DLY_HI])
			dly_ff[15:8] <= bus_s_ff; // see RL7 RL15
		else if (dly_step)
			dly_ff <= dly_ff + 1'b1; // see RL8
	end
	chk_dly_count: assert property (dly_step && !stb_evt[`LCS_STB_DLY_LO] // see RL8
		&& !stb_evt[`LCS_STB_DLY_HI] |=> dly_ff == `LCS_DLY_W'($past(dly_ff) + 1'b1))
		else $error("delay counter missed a step");
	chk_event_gate: assert property (ctrl_ff.by_events && qclk && !trig_hit // see RL9
		&& !(|stb_evt[`LCS_STB_DLY_HI:`LCS_STB_DLY_LO]) |=> $stable(dly_ff))
		else $error("delay counted without second event");

	// tail counter: fixed run of qualified clocks after the middle
	assign end_evt = qclk & (state_ff == LCS_ST_DLY)
		& (tail_ff == `LCS_TAIL_W'(`LCS_TAIL_LEN - 1)); // see RL10
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			tail_ff <= '0;
		else if (state_ff != LCS_ST_DLY)
			tail_ff <= '0;
		else if (qclk)
			tail_ff <= tail_ff + 1'b1; // see RL10
	end
	sequence s_tail_done;
		state_ff == LCS_ST_DLY && end_evt && !clr_cmd;
	endsequence
	sequence s_in_end;
		state_ff == LCS_ST_END ##1 state_ff == LCS_ST_END;
	endsequence
	chk_tail_end: assert property (s_tail_done |=> s_in_end) // see RL10
		else $error("end of capture not reached after tail");
	chk_tail_early: assert property (state_ff == LCS_ST_DLY && tail_ff != '1 // see RL10
		&& !end_evt && !stop_cmd && !force_b_cmd && !clr_cmd |=> state_ff == LCS_ST_DLY)
		else $error("capture ended before tail completed");

	// capture state controller
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			state_ff <= LCS_ST_RESET;
		else if (clr_cmd)
			state_ff <= LCS_ST_RESET; // see RL20
		else begin
			case (state_ff)
				LCS_ST_RESET: begin
					if (arm_cmd)
						state_ff <= LCS_ST_ARMED; // see RL13
				end
				LCS_ST_ARMED: begin
					if (stop_cmd)
						state_ff <= LCS_ST_END;
					else if (flush_done)
						state_ff <= LCS_ST_FLUSHED; // see RL3 RL12
				end
				LCS_ST_FLUSHED: begin
					if (stop_cmd)
						state_ff <= LCS_ST_END;
					else if (trig_a_evt || force_a_cmd)
						state_ff <= LCS_ST_TRIG_A; // see RL12 RL13
				end
				LCS_ST_TRIG_A: begin
					if (stop_cmd)
						state_ff <= LCS_ST_END;
					else if (trig_b_evt || force_b_cmd)
						state_ff <= LCS_ST_TRIG_B; // see RL12 RL19
				end
				LCS_ST_TRIG_B: begin
					if (stop_cmd)
						state_ff <= LCS_ST_END;
					else if (mid_evt || force_b_cmd)
						state_ff <= LCS_ST_DLY; // see RL10 RL12
				end
				LCS_ST_DLY: begin
					if (stop_cmd || end_evt || force_b_cmd)
						state_ff <= LCS_ST_END; // see RL10 RL12
				end
				LCS_ST_END: state_ff <= LCS_ST_END;
				default: state_ff <= LCS_ST_ERR; // see RL20
			endcase
		end
	end
	chk_err_stick: assert property (state_ff == LCS_ST_ERR && !clr_cmd // see RL20
		|=> state_ff == LCS_ST_ERR)
		else $error("error state left without reset strobe");
	chk_flushed_next: assert property (state_ff == LCS_ST_FLUSHED && $changed(state_ff) // see RL12
		|-> $past(state_ff) == LCS_ST_ARMED)
		else $error("flushed state entered from the wrong state");
	chk_a_path: assert property (state_ff == LCS_ST_FLUSHED && !clr_cmd // see RL12
		&& !stop_cmd |=> state_ff inside {LCS_ST_FLUSHED, LCS_ST_TRIG_A})
		else $error("illegal exit from flushed state");
	chk_force_a: assert property (state_ff == LCS_ST_FLUSHED && force_a_cmd // see RL13
		&& !stop_cmd && !clr_cmd |=> state_ff == LCS_ST_TRIG_A)
		else $error("force first event ignored");
	// each state waits for its own event only; commands take their step
	chk_a_wait: assert property (state_ff == LCS_ST_FLUSHED && qclk && !trig_hit // see RL11
		&& !force_a_cmd && !stop_cmd && !clr_cmd |=> state_ff == LCS_ST_FLUSHED)
		else $error("first event taken without a match");
	chk_b_wait: assert property (state_ff == LCS_ST_TRIG_A && qclk && !trig_hit // see RL19
		&& !force_b_cmd && !stop_cmd && !clr_cmd |=> state_ff == LCS_ST_TRIG_A)
		else $error("second event taken without a match");
	chk_arm_step: assert property (state_ff == LCS_ST_RESET && arm_cmd && !clr_cmd // see RL13
		|=> state_ff == LCS_ST_ARMED)
		else $error("arm command ignored");
	chk_stop_end: assert property (stop_cmd && !clr_cmd && state_ff != LCS_ST_RESET // see RL13
		&& state_ff != LCS_ST_ERR |=> state_ff == LCS_ST_END)
		else $error("stop command did not end the capture");
	chk_mid_enter: assert property (state_ff == LCS_ST_TRIG_B && mid_evt // see RL10
		&& !stop_cmd && !clr_cmd |=> state_ff == LCS_ST_DLY && tail_ff == '0)
		else $error("middle of window not followed by tail count");

	// registered status outputs
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			flush_done_ff <= 1'b0;
			capture_done_ff <= 1'b0;
			error_ff <= 1'b0;
		end else begin
			flush_done_ff <= flush_done & (state_ff != LCS_ST_RESET);
			capture_done_ff <= (state_ff == LCS_ST_END);
			error_ff <= (state_ff == LCS_ST_ERR); // see RL20
		end
	end

	// status flags follow the state one clock later
	chk_done_flag: assert property (state_ff == LCS_ST_END |=> capture_done_ff) // see RL12
		else $error("capture done flag missing");
	chk_err_flag: assert property (state_ff == LCS_ST_ERR |=> error_ff) // see RL20
		else $error("error flag missing in unused state");

	assign rd_state_o = state_ff; // see RL14
	assign rd_sample_o = rd_sample_ff;
	assign flush_done_o = flush_done_ff;
	assign capture_done_o = capture_done_ff;
	assign error_o = error_ff;
endmodule

// File: lcs_cfg.svh
// constants for the capture sequencer: strobe numbers, lengths, widths
// assumes nothing; included by the package and the design modules
// Notes on behaviour
// RL1: reset strobe clears sample address counter
// RL2: flush clocks write samples, advance address
// RL3: after 64 flush writes, flush completes
// RL4: flush phase removable by build option
// RL5: writes continue until end of capture
// RL6: processor reads samples by stepping address
// RL7: processor preloads delay counter low/high bytes
// RL8: clock mode: delay counts every qualified clock
// RL9: event mode: delay counts second-event clocks only
// RL10: terminal marks middle; 32 clocks more end
// RL11: three state bits gate next event only
// RL12: fixed gray state sequence, 100 is error
// RL13: hardware events or processor commands advance
// RL14: state bits readable by the processor
// RL15: strobes 0,1,2: trigger bit, delay bytes
// RL16: strobes 4,5,7: read, control load, clear
// RL17: captured samples stay in sample memory
// RL18: control register holds eight documented bits
// RL19: after first event, match second pattern
// RL20: unused state code sticks until reset strobe
`ifndef LCS_CFG_SVH
`define LCS_CFG_SVH
`define LCS_FLUSH_LEN 64
`define LCS_FLUSH_W 7
`define LCS_TAIL_LEN 32
`define LCS_TAIL_W 6
`define LCS_SAMPLE_W 28
`define LCS_GRP_W 7
`define LCS_NGRP 4
`define LCS_TRIG_AW 8
`define LCS_DLY_W 16
`define LCS_MEM_AW 8
`define LCS_FIFO_DEPTH 2
`define LCS_STB_TRIG 0
`define LCS_STB_DLY_LO 1
`define LCS_STB_DLY_HI 2
`define LCS_STB_RD 4
`define LCS_STB_CTRL 5
`define LCS_STB_CLR 7
`define LCS_CTRL_RST 8'h00
`endif

// File: lcs_pkg.sv
// types shared by the capture sequencer modules
// assumes lcs_cfg.svh is on the include path
`include "lcs_cfg.svh"
package lcs_pkg;
	// capture progress, gray coded along the normal path
	typedef enum logic [2:0] {
		LCS_ST_RESET = 3'h0,
		LCS_ST_ARMED = 3'h1,
		LCS_ST_FLUSHED = 3'h3,
		LCS_ST_TRIG_A = 3'h2,
		LCS_ST_TRIG_B = 3'h6,
		LCS_ST_DLY = 3'h7,
		LCS_ST_END = 3'h5,
		LCS_ST_ERR = 3'h4
	} lcs_state_t;
	// capture control register, bit 0 first from the bottom
	typedef struct packed {
		logic qb_pol;
		logic qa_pol;
		logic falling;
		logic by_events;
		logic stop;
		logic force_b;
		logic force_a;
		logic cnt_mode;
	} lcs_ctrl_t;
	// one captured word from the target system
	typedef struct packed {
		logic [3:0] qual;
		logic [7:0] data;
		logic [15:0] addr;
	} lcs_sample_t;
endpackage

// File: lcs_fifo2.sv
// small valid/ready buffer between sample capture and sample memory
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
`include "lcs_cfg.svh"
module lcs_fifo2 import lcs_pkg::*; #(
	parameter int W = `LCS_SAMPLE_W,
	parameter int DEPTH = `LCS_FIFO_DEPTH
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	logic [W-1:0] buf_mem [DEPTH];
	logic [PW-1:0] wr_ptr_ff, rd_ptr_ff;
	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic full_ff, ready_ff;
	logic push, pop;

	// handshakes
	assign push = in_valid_i & ~full_ff;
	assign pop = out_valid_o & out_ready_i;
	assign out_valid_o = (cnt_ff != '0);
	assign out_data_o = buf_mem[rd_ptr_ff];
	assign in_ready_o = ready_ff; // flop copy so the top output is registered
	assign nxt_cnt = cnt_ff + CW'(push) - CW'(pop);

	// storage
	always_ff @(posedge clk_sys_i) begin
		if (push)
			buf_mem[wr_ptr_ff] <= in_data_i;
	end

	// pointers and fill level
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
			full_ff <= 1'b0;
			ready_ff <= 1'b1;
		end else begin
			if (push)
				wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
			cnt_ff <= nxt_cnt;
			full_ff <= (nxt_cnt == CW'(DEPTH));
			ready_ff <= (nxt_cnt != CW'(DEPTH));
		end
	end
endmodule

// File: lcs_proc_model.sv
// processor model: drives the strobe pins and the data bus of the sequencer
// assumes the bench clock; pins change only at its falling edge
`timescale 1ns/1ps
module lcs_proc_model (
	input wire logic clk_sys_i,
	output logic [7:0] strobe_o,
	output logic [7:0] data_bus_o
);
	// pins idle low from time zero
	initial begin
		strobe_o = 8'h00;
		data_bus_o = 8'h00;
	end
	// one strobe pulse; bus held through the high phase, then released
	task automatic pulse(input int pin, input logic [7:0] val);
		@(negedge clk_sys_i);
		data_bus_o = val;
		@(negedge clk_sys_i);
		strobe_o[pin] = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		strobe_o[pin] = 1'b0;
		data_bus_o = ~val; // released bus shows no stale value
		repeat (4) @(negedge clk_sys_i);
	endtask
	// delay preload, low byte first
	task automatic load_delay(input logic [15:0] v);
		pulse(1, v[7:0]);
		pulse(2, v[15:8]);
	endtask
	// control write: arm, force and stop commands ride on it
	task automatic ctrl(input logic [7:0] v);
		pulse(5, v);
	endtask
endmodule

// File: lcs_top_tb.sv
// self-checking bench for the capture sequencer
// assumes lcs_pkg, lcs_top and lcs_proc_model are compiled before it
`timescale 1ns/1ps
module lcs_top_tb import lcs_pkg::*; ;
	localparam lcs_sample_t PAT_A = {4{7'h05}};
	localparam lcs_sample_t PAT_B = {4{7'h0a}};
	localparam lcs_sample_t NOM = 28'h0000123;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic tgt_clk = 1'b0;
	logic [1:0] qual = 2'h0;
	lcs_sample_t smp = '0;
	logic [7:0] stb;
	logic [7:0] bus;
	lcs_sample_t rd_smp;
	lcs_state_t st_q;
	lcs_state_t nf_st;
	logic fl_done;
	logic cap_done;
	logic err;
	logic bready;
	lcs_sample_t nf_smp;
	logic nf_fl, nf_cap, nf_err, nf_rdy;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	lcs_sample_t exp_q[$];

	// system clock, 4 ns period
	always #2 clk_sys_i = ~clk_sys_i;

	// processor model and the two build variants
	lcs_proc_model u_proc (.clk_sys_i(clk_sys_i), .strobe_o(stb), .data_bus_o(bus));
	lcs_top uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .tgt_clk_i(tgt_clk),
		.clk_qual_i(qual), .tgt_sample_i(smp), .control_strobe_port_i(stb),
		.data_bus_i(bus), .rd_sample_o(rd_smp), .rd_state_o(st_q), .flush_done_o(fl_done),
		.capture_done_o(cap_done), .error_o(err), .buf_ready_o(bready));
	lcs_top #(.FLUSH_EN(1'b0)) uut_nf (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.tgt_clk_i(tgt_clk), .clk_qual_i(qual), .tgt_sample_i(smp),
		.control_strobe_port_i(stb), .data_bus_i(bus), .rd_sample_o(nf_smp),
		.rd_state_o(nf_st), .flush_done_o(nf_fl), .capture_done_o(nf_cap), .error_o(nf_err),
		.buf_ready_o(nf_rdy));

	// compare and count
	task automatic check(input logic [27:0] seen, input logic [27:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic st(input lcs_state_t e);
		check(28'(st_q), 28'(e));
	endtask
	// one 80 ns target clock cycle; keep marks a sample that must be stored
	task automatic edge1(input lcs_sample_t s, input bit keep);
		@(negedge clk_sys_i);
		smp = s;
		repeat (9) @(negedge clk_sys_i);
		tgt_clk = 1'b1;
		repeat (10) @(negedge clk_sys_i);
		tgt_clk = 1'b0;
		if (keep)
			exp_q.push_back(s);
	endtask

	task automatic t_reset();
		st(LCS_ST_RESET);
		check(28'({fl_done, cap_done, err, bready}), 28'h1);
		check(28'({nf_fl, nf_cap, nf_err, nf_rdy}), 28'h1);
		$display("test reset done");
	endtask
	// trigger memory: first pattern at 5, second at 128+10
	task automatic t_trig();
		u_proc.pulse(7, 8'h00);
		u_proc.ctrl(8'h01);
		for (int a = 0; a < 256; a++)
			u_proc.pulse(0, (a == 5 || a == 138) ? 8'h0f : 8'h00);
		u_proc.pulse(7, 8'h00);
		st(LCS_ST_RESET);
		$display("test trigger load done");
	endtask
	task automatic t_capture();
		u_proc.load_delay(16'hfffe);
		u_proc.ctrl(8'h00);
		st(LCS_ST_ARMED);
		check(28'(nf_st), 28'(LCS_ST_FLUSHED));
		check(28'(nf_fl), 28'h1);
		for (int i = 0; i < 63; i++)
			edge1(28'(i), 1'b1);
		qual = 2'h1;
		edge1(NOM, 1'b0);
		qual = 2'h0;
		check(28'(fl_done), 28'h0);
		edge1(28'd63, 1'b1);
		check(28'(fl_done), 28'h1);
		st(LCS_ST_FLUSHED);
		edge1(NOM, 1'b1);
		edge1(PAT_B, 1'b1);
		st(LCS_ST_FLUSHED);
		edge1(PAT_A, 1'b1);
		st(LCS_ST_TRIG_A);
		edge1(PAT_A, 1'b1);
		st(LCS_ST_TRIG_A);
		edge1(PAT_B, 1'b1);
		st(LCS_ST_TRIG_B);
		edge1(NOM, 1'b1);
		st(LCS_ST_TRIG_B);
		edge1(NOM, 1'b1);
		st(LCS_ST_DLY);
		for (int i = 0; i < 31; i++)
			edge1(28'(i + 200), 1'b1);
		st(LCS_ST_DLY);
		edge1(NOM, 1'b1);
		st(LCS_ST_END);
		check(28'({cap_done, bready}), 28'h3);
		edge1(28'h0abcdef, 1'b0);
		$display("test capture done");
	endtask
	// step through memory from word 0
	task automatic t_readback();
		u_proc.pulse(7, 8'h00);
		foreach (exp_q[k]) begin
			u_proc.pulse(4, 8'h00);
			check(rd_smp, exp_q[k]);
			check(nf_smp, exp_q[k]);
		end
		u_proc.pulse(4, 8'h00);
		check(28'(rd_smp !== 28'h0abcdef), 28'h1);
		$display("test readback done");
	endtask
	// delay by events, forced triggers, stop
	task automatic t_events();
		u_proc.load_delay(16'hfffe);
		u_proc.ctrl(8'h10);
		for (int i = 0; i < 64; i++)
			edge1(28'(i), 1'b0);
		st(LCS_ST_FLUSHED);
		u_proc.ctrl(8'h12);
		st(LCS_ST_TRIG_A);
		u_proc.ctrl(8'h14);
		st(LCS_ST_TRIG_B);
		edge1(NOM, 1'b0);
		edge1(PAT_B, 1'b0);
		edge1(NOM, 1'b0);
		st(LCS_ST_TRIG_B);
		edge1(PAT_B, 1'b0);
		st(LCS_ST_DLY);
		u_proc.ctrl(8'h18);
		st(LCS_ST_END);
		check(28'({cap_done, nf_cap}), 28'h3);
		$display("test events done");
	endtask
	// falling edge and both qualifier levels decide which samples are kept
	task automatic t_edge();
		u_proc.pulse(7, 8'h00);
		u_proc.ctrl(8'he0);
		qual = 2'h3;
		edge1(28'h0000111, 1'b0);
		@(negedge clk_sys_i);
		qual = 2'h1;
		edge1(NOM, 1'b0);
		@(negedge clk_sys_i);
		qual = 2'h2;
		edge1(NOM, 1'b0);
		@(negedge clk_sys_i);
		qual = 2'h3;
		edge1(28'h0000222, 1'b0);
		st(LCS_ST_ARMED);
		u_proc.pulse(7, 8'h00);
		u_proc.pulse(4, 8'h00);
		check(rd_smp, 28'h0000111);
		u_proc.pulse(4, 8'h00);
		check(rd_smp, 28'h0000222);
		check(nf_smp, 28'h0000222);
		$display("test edge select done");
	endtask

	// verdict and end of run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (20) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		t_reset();
		t_trig();
		t_capture();
		t_readback();
		t_events();
		t_edge();
		stop_test();
	end
	// hang guard
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			stop_test();
		end
	end
endmodule
